/* File: design/amcp_pkg.sv */
// Shared constants of the converter mode-configuration port.
package amcp_pkg;
    // Serial word layout: read flag, seven address bits, eight data bits, MSB first.
    localparam int AMCP_WORD_BITS = 16;
    localparam int AMCP_HDR_BITS = 8;
    localparam int AMCP_RW_POS = 7;
    localparam int AMCP_NUM_REGS = 4;

    // Register indices of the mode control registers.
    localparam logic [6:0] AMCP_REG_RESET = 7'h00;
    localparam logic [6:0] AMCP_REG_POWER = 7'h01;
    localparam logic [6:0] AMCP_REG_TIMING = 7'h02;
    localparam logic [6:0] AMCP_REG_OUTMODE = 7'h03;

    // Field positions.
    localparam int AMCP_SWRST_POS = 7;
    localparam int AMCP_SLEEP_POS = 0;
    localparam int AMCP_NAP_POS = 1;
    localparam int AMCP_DCS_POS = 0;
    localparam int AMCP_OUTPUT_CLOCK_INVERT_POS = 3;
    localparam int AMCP_TERM_POS = 3;
    localparam int AMCP_CUR_LSB = 0;

    // Reset values.
    localparam logic [7:0] AMCP_RST_RESET = 8'h00;
    localparam logic [7:0] AMCP_RST_POWER = 8'h00;
    localparam logic [7:0] AMCP_RST_TIMING = 8'h00;
    localparam logic [7:0] AMCP_RST_OUTMODE = 8'h00;

    // Output current codes.
    localparam logic [2:0] AMCP_CUR_3P5 = 3'h0;
    localparam logic [2:0] AMCP_CUR_4P0 = 3'h1;
    localparam logic [2:0] AMCP_CUR_4P5 = 3'h2;
    localparam logic [2:0] AMCP_CUR_3P0 = 3'h4;
    localparam logic [2:0] AMCP_CUR_2P5 = 3'h5;
    localparam logic [2:0] AMCP_CUR_2P1 = 3'h6;
    localparam logic [2:0] AMCP_CUR_1P75 = 3'h7;

    // Synchroniser idle levels: select, cs_n, sck, sdi, encode_pos, encode_neg.
    // Chip select rests high and the encode pair rests low (negative input high),
    // so no false chip select or encode edge follows reset.
    localparam logic [5:0] AMCP_PIN_IDLE = 6'h11;
endpackage

/* File: design/amcp_sync.sv */
// Two-flop synchroniser bank for the configuration and encode pins.
`timescale 1ns/1ps
module amcp_sync #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Each pin passes two flops; the first one feeds only the second.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge core_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                meta_q[i] <= IDLE[i];
                sync_q[i] <= IDLE[i];
            end else begin
                meta_q[i] <= pins_in[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign sync_out = sync_q;
endmodule

/* File: design/amcp_config_port.sv */
// Mode-configuration port: serial register access or parallel pin strapping.
// Notes on behaviour
// - Select low: chip select, clock, data in and out form a serial port.
// - Select high: chip select, clock and data in are static mode levels.
// - Serial data shifts into registers only while chip select is low.
// - Each input bit is sampled on the rising serial clock edge.
// - Readback drives register bits on open-drain output; host samples falling edge.
// - Parallel mode: data in level picks 3.5mA or 1.75mA driver current.
// - Parallel mode: serial clock level selects sleep or normal operation.
// - Parallel mode: chip select level enables or disables duty cycle stabilizer.
// - Conversion starts on rising positive encode edge, falling complement edge.
// - Serial mode: stabilizer enable and clock inversion share one register.
// - Serial mode: current field offers seven levels, 3.5mA default.
`timescale 1ns/1ps
module amcp_config_port
    import amcp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic programming_select_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    input wire logic encode_pos_in,
    input wire logic encode_neg_in,
    output logic conversion_start_out,
    output logic [2:0] lvds_current_code_out,
    output logic lvds_termination_out,
    output logic sleep_out,
    output logic nap_out,
    output logic dcs_enable_out,
    output logic output_clock_invert_out
);
    // True when an address names an implemented register.
    function automatic logic addr_ok(input logic [6:0] addr);
        addr_ok = (addr < 7'(AMCP_NUM_REGS));
    endfunction

    // Default contents of one register.
    function automatic logic [7:0] reg_default(input int idx);
        case (idx)
            1: reg_default = AMCP_RST_POWER;
            2: reg_default = AMCP_RST_TIMING;
            3: reg_default = AMCP_RST_OUTMODE;
            default: reg_default = AMCP_RST_RESET;
        endcase
    endfunction

    logic [5:0] pins_s;
    logic psel_s, cs_s, sck_s, sdi_s, encp_s, encn_s;

    // All pins come from outside the core clock and are synchronised first.
    amcp_sync #(.WIDTH(6), .IDLE(AMCP_PIN_IDLE)) u_sync (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .pins_in({programming_select_in, cs_n_in, sck_in, sdi_in, encode_pos_in,
                  encode_neg_in}),
        .sync_out(pins_s)
    );

    assign {psel_s, cs_s, sck_s, sdi_s, encp_s, encn_s} = pins_s;

    logic serial_mode;
    logic sck_prev_q, sck_prev_d, sck_rise, sck_fall;
    logic enc_prev_q, enc_prev_d, enc_high, enc_rise;

    assign serial_mode = !psel_s;
    assign sck_rise = sck_s && !sck_prev_q;
    assign sck_fall = !sck_s && sck_prev_q;
    assign enc_high = encp_s && !encn_s;
    assign enc_rise = enc_high && !enc_prev_q;
    assign sck_prev_d = sck_s;
    assign enc_prev_d = enc_high;

    logic [4:0] bit_cnt_q, bit_cnt_d;
    logic [AMCP_WORD_BITS-1:0] shift_q, shift_d;
    logic [7:0] rd_q, rd_d;
    logic reading_q, reading_d;
    logic sdo_oe_q, sdo_oe_d;
    logic [7:0] regs_q [AMCP_NUM_REGS];
    logic [7:0] regs_d [AMCP_NUM_REGS];
    logic wr_strobe;
    logic [6:0] wr_addr;
    logic [6:0] hdr_addr;

    assign hdr_addr = shift_d[AMCP_HDR_BITS-2:0];
    assign wr_addr = shift_d[AMCP_WORD_BITS-2:AMCP_HDR_BITS];

    // Serial shifter, readback path and register writes.
    always_comb begin
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        rd_d = rd_q;
        reading_d = reading_q;
        sdo_oe_d = sdo_oe_q;
        regs_d = regs_q;
        wr_strobe = 1'b0;
        if (!serial_mode || cs_s) begin
            bit_cnt_d = '0;
            reading_d = 1'b0;
            sdo_oe_d = 1'b0;
        end else begin
            if (sck_rise && bit_cnt_q < 5'(AMCP_WORD_BITS)) begin
                shift_d = {shift_q[AMCP_WORD_BITS-2:0], sdi_s};
                bit_cnt_d = bit_cnt_q + 5'd1;
                if (bit_cnt_d == 5'(AMCP_HDR_BITS)) begin
                    reading_d = shift_d[AMCP_RW_POS];
                    rd_d = addr_ok(hdr_addr) ? regs_q[hdr_addr[1:0]] : 8'h00;
                end
                if (bit_cnt_d == 5'(AMCP_WORD_BITS) && !shift_d[AMCP_WORD_BITS-1]) begin
                    wr_strobe = 1'b1;
                end
            end
            if (sck_fall && reading_q && bit_cnt_q >= 5'(AMCP_HDR_BITS) &&
                bit_cnt_q < 5'(AMCP_WORD_BITS)) begin
                sdo_oe_d = !rd_q[7];
                rd_d = {rd_q[6:0], 1'b0};
            end
        end
        if (wr_strobe && addr_ok(wr_addr)) begin
            regs_d[wr_addr[1:0]] = shift_d[7:0];
            if (wr_addr == AMCP_REG_RESET && shift_d[AMCP_SWRST_POS]) begin
                for (int i = 0; i < AMCP_NUM_REGS; i++) begin
                    regs_d[i] = reg_default(i);
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_prev_q <= 1'b0;
            enc_prev_q <= 1'b0;
            bit_cnt_q <= '0;
            shift_q <= '0;
            rd_q <= '0;
            reading_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            for (int i = 0; i < AMCP_NUM_REGS; i++) begin
                regs_q[i] <= reg_default(i);
            end
        end else begin
            sck_prev_q <= sck_prev_d;
            enc_prev_q <= enc_prev_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            rd_q <= rd_d;
            reading_q <= reading_d;
            sdo_oe_q <= sdo_oe_d;
            regs_q <= regs_d;
        end
    end

    logic [2:0] cur_d, cur_q;
    logic term_d, term_q, sleep_d, sleep_q, nap_d, nap_q;
    logic dcs_d, dcs_q, output_clock_invert_d, output_clock_invert_q, conv_d, conv_q;
    logic [2:0] cur_field;

    assign cur_field = regs_q[AMCP_REG_OUTMODE[1:0]][AMCP_CUR_LSB+:3];

    // Mode outputs from registers or from static pin levels.
    always_comb begin
        conv_d = enc_rise;
        if (serial_mode) begin
            cur_d = (cur_field == 3'h3) ? AMCP_CUR_3P5 : cur_field;
            term_d = regs_q[AMCP_REG_OUTMODE[1:0]][AMCP_TERM_POS];
            sleep_d = regs_q[AMCP_REG_POWER[1:0]][AMCP_SLEEP_POS];
            nap_d = regs_q[AMCP_REG_POWER[1:0]][AMCP_NAP_POS];
            dcs_d = regs_q[AMCP_REG_TIMING[1:0]][AMCP_DCS_POS];
            output_clock_invert_d = regs_q[AMCP_REG_TIMING[1:0]][AMCP_OUTPUT_CLOCK_INVERT_POS];
        end else begin
            cur_d = sdi_s ? AMCP_CUR_1P75 : AMCP_CUR_3P5;
            term_d = 1'b0;
            sleep_d = sck_s;
            nap_d = 1'b0;
            dcs_d = !cs_s;
            output_clock_invert_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cur_q <= AMCP_CUR_3P5;
            term_q <= 1'b0;
            sleep_q <= 1'b0;
            nap_q <= 1'b0;
            dcs_q <= 1'b0;
            output_clock_invert_q <= 1'b0;
            conv_q <= 1'b0;
        end else begin
            cur_q <= cur_d;
            term_q <= term_d;
            sleep_q <= sleep_d;
            nap_q <= nap_d;
            dcs_q <= dcs_d;
            output_clock_invert_q <= output_clock_invert_d;
            conv_q <= conv_d;
        end
    end

    // Output pins; the open-drain output only ever pulls low.
    assign sdo_out = 1'b0;
    assign sdo_oe_out = sdo_oe_q;
    assign conversion_start_out = conv_q;
    assign lvds_current_code_out = cur_q;
    assign lvds_termination_out = term_q;
    assign sleep_out = sleep_q;
    assign nap_out = nap_q;
    assign dcs_enable_out = dcs_q;
    assign output_clock_invert_out = output_clock_invert_q;

    // Checks on the port behaviour.
    a_cs_high_release: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        cs_s |=> !sdo_oe_out)
        else $error("serial output driven while deselected");
    a_write_when_sel: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        wr_strobe |-> !cs_s && serial_mode && $past(bit_cnt_q) == 5'd15)
        else $error("register write outside a selected sixteen bit word");
    a_sample_rising: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (serial_mode && !cs_s && !sck_rise) |=> $stable(bit_cnt_q) && $stable(shift_q))
        else $error("shifter moved without a rising serial clock");
    a_sdo_on_fall: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(sdo_oe_out) |-> $past(sck_fall) && $past(reading_q))
        else $error("serial output changed away from a falling edge");
    a_par_current: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (psel_s && $past(psel_s)) |=> lvds_current_code_out ==
            ($past(sdi_s) ? AMCP_CUR_1P75 : AMCP_CUR_3P5))
        else $error("parallel current does not follow data-in level");
    a_par_sleep: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        psel_s |=> sleep_out == $past(sck_s) && !nap_out)
        else $error("parallel sleep does not follow clock level");
    a_par_dcs: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        psel_s |=> dcs_enable_out == !$past(cs_s))
        else $error("parallel stabilizer does not follow select level");
    a_encode_start: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        enc_rise |=> conversion_start_out ##1 !conversion_start_out)
        else $error("conversion start not a single pulse on encode rise");
    a_timing_held: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        !wr_strobe |=> $stable(regs_q[AMCP_REG_TIMING[1:0]]))
        else $error("register changed without a write");
    a_serial_dcs: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        serial_mode |=> dcs_enable_out == $past(regs_q[AMCP_REG_TIMING[1:0]][AMCP_DCS_POS]))
        else $error("serial stabilizer does not follow its register");
    a_serial_cur: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        serial_mode |=> lvds_current_code_out != 3'h3)
        else $error("reserved current code reached the driver");
endmodule

/* File: verif/amcp_host_model.sv */
// Host controller model that drives the serial configuration pins.
`timescale 1ns/1ps
module amcp_host_model (
    input wire logic sdo_line_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic sdi_out
);
    // Pins idle with chip select released and the serial clock parked low.
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        sdi_out = 1'b0;
    end

    // Shifts one word MSB first; the last eight bits seen on the data line come back.
    // serial port use
    task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
        rd = 8'h00;
        cs_n_out = 1'b0;
        #80;
        for (int i = 15; i >= 0; i--) begin
            sdi_out = word[i];
            #80 sck_out = 1'b1;
            #80 sck_out = 1'b0;
            if (i <= 7) begin
                rd = {rd[6:0], sdo_line_in};
            end
        end
        #80 cs_n_out = 1'b1;
        sdi_out = ~sdi_out; // A released line must not keep its last value.
        // Keep chip select high long enough for the port to end the frame.
        #80;
    endtask

    // Toggles clock and data while chip select stays high.
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            sdi_out = ~sdi_out;
            #80 sck_out = 1'b1;
            #80 sck_out = 1'b0;
        end
    endtask

    // Holds the three pins as static levels for strapped operation.
    // static pin levels
    task automatic levels(input logic c, input logic s, input logic d);
        cs_n_out = c;
        sck_out = s;
        sdi_out = d;
    endtask
endmodule

/* File: verif/tb.sv */
// Self-checking testbench of the mode-configuration port.
`timescale 1ns/1ps
module tb;
    import amcp_pkg::*;
    logic core_clk_in, reset_n_in, sel, cs_n, sck, sdi, sdo, sdo_oe, ep, en, conv;
    logic [2:0] code;
    logic term, slp, nap, dcs, inv;
    logic sdo_line;
    logic [7:0] rd;
    int bad_count = 0;
    int compares = 0;
    int conv_cnt = 0;

    // The open-drain line is pulled up whenever the port lets go of it.
    assign sdo_line = sdo_oe ? sdo : 1'b1;

    amcp_config_port dut_u (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .programming_select_in(sel), .cs_n_in(cs_n), .sck_in(sck), .sdi_in(sdi),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .encode_pos_in(ep), .encode_neg_in(en),
        .conversion_start_out(conv), .lvds_current_code_out(code),
        .lvds_termination_out(term), .sleep_out(slp), .nap_out(nap),
        .dcs_enable_out(dcs), .output_clock_invert_out(inv));

    amcp_host_model host_u (.sdo_line_in(sdo_line), .cs_n_out(cs_n), .sck_out(sck),
        .sdi_out(sdi));

    // Core clock at 50 MHz.
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    // Counts conversion start pulses.
    always @(posedge core_clk_in) begin
        if (conv === 1'b1) begin
            conv_cnt++;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic rst(input logic s);
        reset_n_in = 1'b0;
        sel = s;
        repeat (16) @(posedge core_clk_in);
        #2 reset_n_in = 1'b1;
        repeat (6) @(posedge core_clk_in);
        #2;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b0, a, d}, rd);
        repeat (10) @(posedge core_clk_in);
        #2;
    endtask

    task automatic outs(input logic [7:0] c, input logic [4:0] f);
        chk({5'h00, code}, c);
        chk({3'h0, term, slp, nap, dcs, inv}, {3'h0, f});
    endtask

    task automatic t_reset();
        outs(8'h00, 5'h00);
        chk({6'h00, sdo_oe, conv}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_serial();
        logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
        for (int i = 0; i < 7; i++) begin
            wr(AMCP_REG_OUTMODE, {4'h0, i[0], codes[i]});
            outs({5'h00, codes[i]}, {i[0], 4'h0});
            host_u.xfer({1'b1, AMCP_REG_OUTMODE, 8'h00}, rd);
            chk(rd, {4'h0, i[0], codes[i]});
        end
        wr(AMCP_REG_TIMING, 8'h09);
        outs(8'h07, 5'h03);
        wr(AMCP_REG_POWER, 8'h01);
        outs(8'h07, 5'h0B);
        wr(AMCP_REG_POWER, 8'h02);
        outs(8'h07, 5'h07);
        host_u.xfer({1'b1, AMCP_REG_TIMING, 8'h00}, rd);
        chk(rd, 8'h09);
        $display("test serial done");
    endtask

    task automatic t_ignore();
        host_u.noise(24);
        repeat (6) @(posedge core_clk_in);
        #2;
        outs(8'h07, 5'h07);
        chk({7'h00, sdo_oe}, 8'h00);
        $display("test ignore done");
    endtask

    task automatic t_defaults();
        wr(AMCP_REG_OUTMODE, 8'h03);
        outs(8'h00, 5'h07);
        wr(7'h05, 8'hFF);
        outs(8'h00, 5'h07);
        host_u.xfer({1'b1, 7'h05, 8'h00}, rd);
        chk(rd, 8'h00);
        wr(AMCP_REG_RESET, 8'h80);
        outs(8'h00, 5'h00);
        $display("test defaults done");
    endtask

    task automatic t_encode();
        conv_cnt = 0;
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk_in) #2 ep = 1'b1;
            en = 1'b0;
            repeat (4) @(posedge core_clk_in);
            #2 ep = 1'b0;
            en = 1'b1;
            repeat (4) @(posedge core_clk_in);
        end
        repeat (6) @(posedge core_clk_in);
        #2;
        chk(conv_cnt[7:0], 8'h05);
        $display("test encode done");
    endtask

    task automatic t_parallel();
        logic [2:0] v;
        rst(1'b1);
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            host_u.levels(v[2], v[1], v[0]);
            repeat (6) @(posedge core_clk_in);
            #2;
            chk({5'h00, code}, v[0] ? 8'h07 : 8'h00);
            chk({7'h00, slp}, {7'h00, v[1]});
            chk({7'h00, dcs}, {7'h00, ~v[2]});
            chk({5'h00, term, nap, inv}, 8'h00);
        end
        $display("test parallel done");
    endtask

    // Watchdog cuts a hang short.
    initial begin
        #1000000;
        bad_count++;
        conclude();
    end

    // Main sequence.
    initial begin
        reset_n_in = 1'b0;
        sel = 1'b0;
        ep = 1'b0;
        en = 1'b1;
        rst(1'b0);
        t_reset();
        t_serial();
        t_ignore();
        t_defaults();
        t_encode();
        t_parallel();
        conclude();
    end
endmodule
